// ---- rcfu_pkg.sv ----
// rcfu_pkg: constants, register map and carrier types for the cell routing filter unit.
// assumes one 125 MHz clock domain; all inputs synchronous to it.
package rcfu_pkg;

	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int RCFU_CLK_MHZ = 125;
	localparam int RCFU_RAM_CLK_DIV = 8;
	localparam logic [2:0] RCFU_DIV_LAST = 3'(RCFU_RAM_CLK_DIV - 1);
	localparam int RCFU_STAGE_W = 3;
	localparam int RCFU_RXQ_DEPTH = 4;
	localparam logic [2:0] RCFU_RXQ_FULL = 3'(RCFU_RXQ_DEPTH);

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] RCFU_A_MODE = 8'h00;
	localparam logic [7:0] RCFU_A_FMASK = 8'h04;
	localparam logic [7:0] RCFU_A_IDENT = 8'h08;
	localparam logic [7:0] RCFU_A_STAGE = 8'h0c;
	localparam logic [7:0] RCFU_A_QMAP_LO = 8'h10;
	localparam logic [7:0] RCFU_A_QMAP_HI = 8'h14;
	localparam logic [7:0] RCFU_A_TX0 = 8'h18;
	localparam logic [7:0] RCFU_A_TX1 = 8'h1c;
	localparam logic [7:0] RCFU_A_RXDATA = 8'h20;
	localparam logic [7:0] RCFU_A_STATUS = 8'h24;
	localparam logic [7:0] RCFU_A_TBL_ADDR = 8'h28;
	localparam logic [7:0] RCFU_A_TBL_DATA = 8'h2c;

	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	localparam int RCFU_M_POS_LSB = 0;
	localparam int RCFU_M_WID_LSB = 5;
	localparam int RCFU_M_SPLIT_N_LSB = 8;
	localparam int RCFU_M_SPLIT_EN = 13;
	localparam int RCFU_M_IGN_MC = 14;
	localparam int RCFU_M_BLOCK = 15;
	localparam int RCFU_M_BUNDLE_LSB = 16;
	localparam int RCFU_M_TSHIFT_LSB = 19;
	localparam logic [31:0] RCFU_MODE_RST = 32'h0000_0080;
	localparam logic [63:0] RCFU_QMAP_RST = 64'hfedc_ba98_7654_3210;

	// status bits
	localparam int RCFU_S_OVF = 3;
	localparam int RCFU_S_BUSY = 4;
	localparam int RCFU_S_TX0 = 5;

	typedef enum logic [1:0] {
		RCFU_ST_IDLE = 2'b01,
		RCFU_ST_TABLE = 2'b10
	} rcfu_phase_e;

	typedef struct packed {
		logic self_route;
		logic [RCFU_STAGE_W-1:0] stage;
		logic [4:0] in_port;
		logic [31:0] tag;
	} rcfu_cell_s;

	typedef struct packed {
		logic valid;
		logic test;
		logic drop;
		logic extract;
		logic [15:0] ports;
		logic [15:0] queues;
	} rcfu_route_s;

	typedef struct packed {
		rcfu_phase_e phase;
		logic [31:0] mode;
		logic [31:0] fmask;
		logic [31:0] ident;
		logic [RCFU_STAGE_W-1:0] stage_no;
		logic [63:0] qmap;
		logic [1:0] tx_pend;
		logic [1:0][3:0] tx_out;
		logic [RCFU_RXQ_DEPTH-1:0][31:0] rxq;
		logic [1:0] rx_rd;
		logic [1:0] rx_wr;
		logic [2:0] rx_cnt;
		logic rx_ovf;
		logic [15:0] lk_addr;
		logic [15:0] tbl_addr;
		logic [15:0] tbl_data;
		logic tbl_wr_pend;
		logic tbl_wr_act;
		logic tbl_armed;
		logic [2:0] clk_div;
		rcfu_route_s route;
		logic [31:0] rdata;
	} rcfu_state_s;

	localparam rcfu_state_s RCFU_STATE_RST = '{
		phase: RCFU_ST_IDLE, mode: RCFU_MODE_RST, qmap: RCFU_QMAP_RST, default: '0};

endpackage : rcfu_pkg

// ---- rcfu_top.sv ----
// rcfu_top: routing decision, input filter, split mode, bundles, test cell
// insertion and extraction, and the external multicast table RAM port.
// assumes cell headers arrive one at a time on a valid/ready port and that
// the RAM answers within one slow RAM clock period.
//
// Behaviour
// - self-route output number from up to four contiguous tag bits at configured position.
// - self-routing cells go to the output decoded from the selected bits.
// - table cells use routing pattern as table address; set bits select outputs.
// - multicast table lives in external RAM with a 16-bit address bus.
// - accept a cell only when masked tag bits equal the identification value.
// - masked-out bits always match; all masked means accept every cell.
// - option to ignore multicast indication and self-route such cells.
// - cell for a bundle member may leave on any output of the bundle.
// - one 16-bundle plus all bits masked acts as plain multiplexer.
// - physical output follows output multiplexer map, possibly several outputs.
// - split mode value n divides inputs into lower and higher groups.
// - inputs below n route by tag bits 0..3, fixed filter on bits 4,5.
// - inputs n..31 use programmable routing bits and maskable filter.
// - two single-cell transmit buffers and a receive queue toward the processor.
// - test cells go to the named output, bypassing bundles and multiplexer map.
// - extract cells whose stage number is non-zero and equals this chip's.
// - filter is checked first; only passing cells are tested for extraction.
// - non-zero stage number cells are never treated as multicast.
// - option blocks all cells except test or communication cells.
// - table RAM clock runs at one eighth of the operating clock.
`timescale 1ns/1ns
module rcfu_top
	import rcfu_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// cell header in
	input wire rcfu_pkg::rcfu_cell_s cell_in,
	input wire logic cell_valid_in,
	output logic cell_ready_out,
	// routing decision out
	output rcfu_pkg::rcfu_route_s route_out,
	// multicast table ram
	output logic table_ram_clock_out,
	output logic [15:0] table_ram_addr_out,
	output logic table_ram_oe_b_out,
	output logic table_ram_we_b_out,
	input wire logic [15:0] table_ram_data_in,
	output logic [15:0] table_ram_data_out,
	output logic table_ram_data_oe_out
);
	import rcfu_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_pipe_r;
	logic rst_b;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_b = rst_pipe_r[1];

	rcfu_state_s s_r;
	rcfu_state_s s_nxt;

	// ------------------------------------------------------------
	// header decode
	// ------------------------------------------------------------
	logic [4:0] route_pos;
	logic [2:0] route_wid;
	logic [4:0] split_n;
	logic [2:0] bundle_code;
	logic [4:0] tbl_shift;
	logic split_low;
	logic filt_ok;
	logic stage_hit;
	logic is_table;
	logic [31:0] tag_sh;
	logic [31:0] tag_tsh;
	logic [3:0] wid_mask;
	logic [3:0] self_num;
	logic [15:0] bundle_q;
	logic [15:0] qsel;
	logic [15:0] phys;
	logic take;
	logic tx_any;

	assign route_pos = s_r.mode[RCFU_M_POS_LSB +: 5];
	assign route_wid = s_r.mode[RCFU_M_WID_LSB +: 3];
	assign split_n = s_r.mode[RCFU_M_SPLIT_N_LSB +: 5];
	assign bundle_code = s_r.mode[RCFU_M_BUNDLE_LSB +: 3];
	assign tbl_shift = s_r.mode[RCFU_M_TSHIFT_LSB +: 5];

	assign split_low = s_r.mode[RCFU_M_SPLIT_EN] && (cell_in.in_port < split_n);

	// split lower group has its own fixed two-bit field, no mask
	assign filt_ok = split_low ? (cell_in.tag[5:4] == s_r.ident[5:4])
		: (((cell_in.tag ^ s_r.ident) & s_r.fmask) == 32'h0);

	assign stage_hit = (cell_in.stage != '0) && (cell_in.stage == s_r.stage_no);

	// a non-zero stage number never goes to the table
	assign is_table = !cell_in.self_route && (cell_in.stage == '0)
		&& !s_r.mode[RCFU_M_IGN_MC] && !split_low;

	assign tag_sh = cell_in.tag >> route_pos;
	assign tag_tsh = cell_in.tag >> tbl_shift;

	always_comb begin
		unique case (route_wid)
			3'h0: wid_mask = 4'h0;
			3'h1: wid_mask = 4'h1;
			3'h2: wid_mask = 4'h3;
			3'h3: wid_mask = 4'h7;
			default: wid_mask = 4'hf;
		endcase
	end

	assign self_num = split_low ? cell_in.tag[3:0] : (tag_sh[3:0] & wid_mask);

	// whole bundle is offered; the queue stage picks the member
	always_comb begin
		unique case (bundle_code)
			3'h0: bundle_q = 16'h0001 << self_num;
			3'h1: bundle_q = 16'h0003 << {self_num[3:1], 1'b0};
			3'h2: bundle_q = 16'h000f << {self_num[3:2], 2'b00};
			3'h3: bundle_q = 16'h00ff << {self_num[3], 3'b000};
			default: bundle_q = 16'hffff;
		endcase
	end

	assign qsel = (s_r.phase == RCFU_ST_TABLE) ? table_ram_data_in : bundle_q;

	// ------------------------------------------------------------
	// output multiplexer map
	// ------------------------------------------------------------
	for (genvar p = 0; p < 16; p++) begin : g_out_map
		assign phys[p] = qsel[s_r.qmap[p*4 +: 4]];
	end

	assign tx_any = |s_r.tx_pend;
	// injections, table writes and lookups all own the decision path
	assign cell_ready_out = (s_r.phase == RCFU_ST_IDLE) && !tx_any
		&& !s_r.tbl_wr_pend && !s_r.tbl_wr_act;
	assign take = cell_valid_in && cell_ready_out;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic push;
		logic pop;
		logic [1:0] txi;
		push = 1'b0;
		pop = 1'b0;
		txi = 2'h0;
		s_nxt = s_r;
		s_nxt.route = '0;
		s_nxt.clk_div = s_r.clk_div + 3'h1;

		// register writes
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				RCFU_A_MODE: s_nxt.mode = reg_wdata_in;
				RCFU_A_FMASK: s_nxt.fmask = reg_wdata_in;
				RCFU_A_IDENT: s_nxt.ident = reg_wdata_in;
				RCFU_A_STAGE: s_nxt.stage_no = reg_wdata_in[RCFU_STAGE_W-1:0];
				RCFU_A_QMAP_LO: s_nxt.qmap[31:0] = reg_wdata_in;
				RCFU_A_QMAP_HI: s_nxt.qmap[63:32] = reg_wdata_in;
				RCFU_A_TX0, RCFU_A_TX1: begin
					txi = {1'b0, reg_addr_in[2]};
					// a loaded buffer ignores new writes until sent
					if (!s_r.tx_pend[txi[0]]) begin
						s_nxt.tx_pend[txi[0]] = 1'b1;
						s_nxt.tx_out[txi[0]] = reg_wdata_in[3:0];
					end
				end
				RCFU_A_STATUS: begin
					if (reg_wdata_in[RCFU_S_OVF]) begin
						s_nxt.rx_ovf = 1'b0;
					end
				end
				RCFU_A_TBL_ADDR: s_nxt.tbl_addr = reg_wdata_in[15:0];
				RCFU_A_TBL_DATA: begin
					s_nxt.tbl_data = reg_wdata_in[15:0];
					s_nxt.tbl_wr_pend = 1'b1;
				end
				default: ;
			endcase
		end

		// register reads, data one cycle later
		if (reg_rd_in) begin
			s_nxt.rdata = 32'h0;
			unique case (reg_addr_in)
				RCFU_A_MODE: s_nxt.rdata = s_r.mode;
				RCFU_A_FMASK: s_nxt.rdata = s_r.fmask;
				RCFU_A_IDENT: s_nxt.rdata = s_r.ident;
				RCFU_A_STAGE: s_nxt.rdata = 32'(s_r.stage_no);
				RCFU_A_QMAP_LO: s_nxt.rdata = s_r.qmap[31:0];
				RCFU_A_QMAP_HI: s_nxt.rdata = s_r.qmap[63:32];
				RCFU_A_TX0: s_nxt.rdata = {s_r.tx_pend[0], 27'h0, s_r.tx_out[0]};
				RCFU_A_TX1: s_nxt.rdata = {s_r.tx_pend[1], 27'h0, s_r.tx_out[1]};
				RCFU_A_RXDATA: begin
					if (s_r.rx_cnt != 3'h0) begin
						s_nxt.rdata = s_r.rxq[s_r.rx_rd];
						pop = 1'b1;
					end
				end
				RCFU_A_STATUS: s_nxt.rdata = {25'h0, s_r.tx_pend,
					s_r.phase == RCFU_ST_TABLE, s_r.rx_ovf, s_r.rx_cnt};
				RCFU_A_TBL_ADDR: s_nxt.rdata = {16'h0, s_r.tbl_addr};
				RCFU_A_TBL_DATA: s_nxt.rdata = {16'h0, s_r.tbl_data};
				default: s_nxt.rdata = 32'h0;
			endcase
		end

		// decision path
		unique case (s_r.phase)
			RCFU_ST_IDLE: begin
				if (tx_any) begin
					// test cells skip bundles and the output map
					txi = s_r.tx_pend[0] ? 2'h0 : 2'h1;
					s_nxt.route.valid = 1'b1;
					s_nxt.route.test = 1'b1;
					s_nxt.route.ports = 16'h0001 << s_r.tx_out[txi[0]];
					s_nxt.tx_pend[txi[0]] = 1'b0;
				end else if (take) begin
					s_nxt.route.valid = 1'b1;
					if (!filt_ok) begin
						s_nxt.route.drop = 1'b1;
					end else if (stage_hit) begin
						s_nxt.route.extract = 1'b1;
						push = 1'b1;
					end else if (s_r.mode[RCFU_M_BLOCK] && cell_in.stage == '0) begin
						s_nxt.route.drop = 1'b1;
					end else if (is_table) begin
						s_nxt.route.valid = 1'b0;
						s_nxt.lk_addr = tag_tsh[15:0];
						s_nxt.tbl_armed = 1'b0;
						s_nxt.phase = RCFU_ST_TABLE;
					end else begin
						s_nxt.route.ports = phys;
						s_nxt.route.queues = bundle_q;
					end
				end else if (s_r.tbl_wr_pend && !s_r.tbl_wr_act
					&& s_r.clk_div == RCFU_DIV_LAST) begin
					// a new data write in this same cycle stays pending for the next slot
					s_nxt.tbl_wr_pend = reg_wr_in && reg_addr_in == RCFU_A_TBL_DATA;
					s_nxt.tbl_wr_act = 1'b1;
				end
			end
			RCFU_ST_TABLE: begin
				// wait for a full slow clock period before sampling
				if (s_r.clk_div == RCFU_DIV_LAST) begin
					if (!s_r.tbl_armed) begin
						s_nxt.tbl_armed = 1'b1;
					end else begin
						s_nxt.tbl_armed = 1'b0;
						s_nxt.route.valid = 1'b1;
						s_nxt.route.ports = phys;
						s_nxt.route.queues = table_ram_data_in;
						s_nxt.phase = RCFU_ST_IDLE;
					end
				end
			end
			default: s_nxt.phase = RCFU_ST_IDLE;
		endcase

		// a table write covers exactly one slow clock period
		if (s_r.tbl_wr_act && s_r.clk_div == RCFU_DIV_LAST) begin
			s_nxt.tbl_wr_act = 1'b0;
		end

		// receive queue; overflow set wins over the software clear
		if (push) begin
			if (s_r.rx_cnt == RCFU_RXQ_FULL && !pop) begin
				s_nxt.rx_ovf = 1'b1;
				push = 1'b0;
			end else begin
				s_nxt.rxq[s_r.rx_wr] = cell_in.tag;
				s_nxt.rx_wr = s_r.rx_wr + 2'h1;
			end
		end
		if (pop) begin
			s_nxt.rx_rd = s_r.rx_rd + 2'h1;
		end
		s_nxt.rx_cnt = s_r.rx_cnt + {2'h0, push} - {2'h0, pop};
	end

	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= RCFU_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_out = s_r.rdata;
	assign route_out = s_r.route;
	assign table_ram_clock_out = s_r.clk_div[2];
	assign table_ram_addr_out = s_r.tbl_wr_act ? s_r.tbl_addr : s_r.lk_addr;
	assign table_ram_oe_b_out = !(s_r.phase == RCFU_ST_TABLE);
	assign table_ram_we_b_out = !s_r.tbl_wr_act;
	assign table_ram_data_out = s_r.tbl_data;
	assign table_ram_data_oe_out = s_r.tbl_wr_act;

endmodule : rcfu_top

// ---- rcfu_top_asserts.sv ----
// rcfu_top_asserts: port-level checks on the cell routing filter unit.
// assumes the single clk_in domain; bound onto every rcfu_top instance.
`timescale 1ns/1ns
module rcfu_top_asserts
	import rcfu_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// cell port
	input wire rcfu_pkg::rcfu_cell_s cell_in,
	input wire logic cell_valid_in,
	input wire logic cell_ready_out,
	input wire rcfu_pkg::rcfu_route_s route_out,
	// table ram
	input wire logic table_ram_clock_out,
	input wire logic table_ram_oe_b_out,
	input wire logic table_ram_we_b_out,
	input wire logic table_ram_data_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic taken;
	assign taken = cell_valid_in && cell_ready_out;
	sequence s_ram_write;
		!table_ram_we_b_out [*8] ##1 table_ram_we_b_out;
	endsequence
	sequence s_ram_high;
		table_ram_clock_out [*4] ##1 !table_ram_clock_out;
	endsequence
	a_ram_clk_period: assert property ($rose(table_ram_clock_out) |-> ##8 $rose(table_ram_clock_out))
		else $error("table ram clock period wrong");
	a_ram_clk_duty: assert property ($rose(table_ram_clock_out) |-> s_ram_high)
		else $error("table ram clock high phase wrong");
	a_ram_write_len: assert property ($fell(table_ram_we_b_out) |-> s_ram_write)
		else $error("table write strobe length wrong");
	a_ram_data_drive: assert property (table_ram_data_oe_out == !table_ram_we_b_out)
		else $error("table data drive not with write strobe");
	a_table_answer: assert property ($fell(table_ram_oe_b_out) |-> !cell_ready_out ##[1:17] route_out.valid)
		else $error("table lookup not answered in time");
	a_self_answer: assert property (taken && cell_in.self_route |=> route_out.valid)
		else $error("self routed cell not answered next cycle");
	a_stage_no_mc: assert property (taken && (cell_in.stage != '0) |=> route_out.valid)
		else $error("staged cell handled as table cell");
	a_test_single: assert property (route_out.valid && route_out.test |-> $onehot(route_out.ports))
		else $error("test cell not on a single output");
	a_extract_pass: assert property (route_out.extract |-> route_out.valid && !route_out.drop)
		else $error("extracted cell failed filter");
endmodule : rcfu_top_asserts

bind rcfu_top rcfu_top_asserts chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .cell_in(cell_in),
	.cell_valid_in(cell_valid_in), .cell_ready_out(cell_ready_out), .route_out(route_out),
	.table_ram_clock_out(table_ram_clock_out), .table_ram_oe_b_out(table_ram_oe_b_out),
	.table_ram_we_b_out(table_ram_we_b_out), .table_ram_data_oe_out(table_ram_data_oe_out));

// ---- rcfu_ram_model.sv ----
// rcfu_ram_model: external multicast table ram, 256 words decoded.
// assumes the unit samples read data on clk_in while output enable is low.
`timescale 1ns/1ns
module rcfu_ram_model (
	// ram pins
	input wire logic clk_in,
	input wire logic [15:0] addr_in,
	input wire logic oe_b_in,
	input wire logic we_b_in,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out
);
	logic [15:0] mem [0:255];
	logic [15:0] last_r = 16'h0000;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
	always @(posedge clk_in) begin
		if (!we_b_in) mem[addr_in[7:0]] <= data_in;
		if (!oe_b_in) last_r <= mem[addr_in[7:0]];
	end
	// released bus shows inverted data so stale reads are caught
	assign data_out = !oe_b_in ? mem[addr_in[7:0]] : ~last_r;
endmodule : rcfu_ram_model

// ---- rcfu_top_test.sv ----
// rcfu_top_test: self-checking bench for the cell routing filter unit.
// assumes rcfu_top, rcfu_ram_model and the bound checker are compiled.
`timescale 1ns/1ns
module rcfu_top_test;
	import rcfu_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] ra = 8'h00;
	logic [31:0] rwd = 32'h0;
	logic rw = 1'b0;
	logic rr = 1'b0;
	rcfu_cell_s cc = '0;
	logic cv = 1'b0;
	logic [31:0] rdata;
	logic ready, rck, oe_b, we_b, doe;
	rcfu_route_s ro, rt;
	logic [15:0] raddr, dout, rout, bus;
	int bad_count = 0;
	int n_checks = 0;
	always #4 clk_in = ~clk_in;
	assign bus = doe ? dout : rout;
	rcfu_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(ra), .reg_wdata_in(rwd),
		.reg_wr_in(rw), .reg_rd_in(rr), .reg_rdata_out(rdata), .cell_in(cc), .cell_valid_in(cv),
		.cell_ready_out(ready), .route_out(ro), .table_ram_clock_out(rck),
		.table_ram_addr_out(raddr), .table_ram_oe_b_out(oe_b), .table_ram_we_b_out(we_b),
		.table_ram_data_in(bus), .table_ram_data_out(dout), .table_ram_data_oe_out(doe));
	rcfu_ram_model ram_u (.clk_in(rck), .addr_in(raddr), .oe_b_in(oe_b), .we_b_in(we_b),
		.data_in(bus), .data_out(rout));
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [34:0] s, input logic [34:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic rcfu_route_s rx(input logic [15:0] p, input logic [15:0] q);
		return {4'b1000, p, q};
	endfunction : rx
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in); ra <= a; rwd <= d; rw <= 1'b1;
		@(posedge clk_in); rw <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in); ra <= a; rr <= 1'b1;
		@(posedge clk_in); rr <= 1'b0;
		#1 chk("rdata", 35'(rdata), 35'(e));
	endtask : rd
	// bounded wait for a routing decision
	task automatic wv;
		int i;
		i = 0;
		#1;
		while (ro.valid !== 1'b1 && i < 40) begin
			@(posedge clk_in); #1; i++;
		end
		rt = ro;
		if (i == 40) chk("route timeout", 35'(0), 35'(1));
	endtask : wv
	task automatic snd(input rcfu_cell_s c);
		int i;
		i = 0;
		@(posedge clk_in); cc <= c; cv <= 1'b1;
		#1;
		while (!ready && i < 60) begin
			@(posedge clk_in); #1; i++;
		end
		@(posedge clk_in); cv <= 1'b0;
		wv;
	endtask : snd
	// ----
	// scenarios
	// ----
	task automatic t_self;
		rd(RCFU_A_MODE, RCFU_MODE_RST);
		rd(8'h30, 32'h0);
		wr(RCFU_A_MODE, 32'h88);
		for (int n = 0; n < 16; n++) begin
			snd({1'b1, 3'h0, 5'd1, 32'(n) << 8});
			chk("self", rt, rx(16'h1 << n, 16'h1 << n));
		end
	endtask : t_self
	task automatic t_filter;
		wr(RCFU_A_FMASK, 32'hfff0_0000);
		wr(RCFU_A_IDENT, 32'hb470_0000);
		snd({1'b1, 3'h0, 5'd2, 32'hb470_0300});
		chk("match", rt, rx(16'h0008, 16'h0008));
		snd({1'b1, 3'h0, 5'd2, 32'hb460_0300});
		chk("miss", 35'(rt.drop), 35'(1));
		wr(RCFU_A_FMASK, 32'h0);
		snd({1'b1, 3'h0, 5'd2, 32'h0000_0300});
		chk("masked", rt, rx(16'h0008, 16'h0008));
	endtask : t_filter
	task automatic t_bundle;
		wr(RCFU_A_MODE, 32'h0002_0088);
		snd({1'b1, 3'h0, 5'd0, 32'h0000_0200});
		chk("bundle", rt, rx(16'h000f, 16'h000f));
		wr(RCFU_A_MODE, 32'h0004_0088);
		snd({1'b1, 3'h0, 5'd0, 32'h0000_0900});
		chk("mux", rt, rx(16'hffff, 16'hffff));
		wr(RCFU_A_MODE, 32'h0001_0088);
		snd({1'b1, 3'h0, 5'd0, 32'h0000_0300});
		chk("pair", rt, rx(16'h000c, 16'h000c));
		wr(RCFU_A_MODE, 32'h0003_0088);
		snd({1'b1, 3'h0, 5'd0, 32'h0000_0900});
		chk("octet", rt, rx(16'hff00, 16'hff00));
		wr(RCFU_A_MODE, 32'h48);
		snd({1'b1, 3'h0, 5'd0, 32'h0000_0f00});
		chk("narrow", rt, rx(16'h0008, 16'h0008));
		wr(RCFU_A_MODE, 32'h88);
		wr(RCFU_A_QMAP_LO, 32'h7654_3200);
		snd({1'b1, 3'h0, 5'd0, 32'h0});
		chk("dup", rt, rx(16'h0003, 16'h0001));
		snd({1'b1, 3'h0, 5'd0, 32'h100});
		chk("orphan", rt, rx(16'h0000, 16'h0002));
		wr(RCFU_A_QMAP_LO, RCFU_QMAP_RST[31:0]);
	endtask : t_bundle
	task automatic t_split;
		wr(RCFU_A_IDENT, 32'h20);
		wr(RCFU_A_MODE, 32'h2488);
		snd({1'b1, 3'h0, 5'd3, 32'h27});
		chk("split low", rt, rx(16'h0080, 16'h0080));
		snd({1'b1, 3'h0, 5'd3, 32'h17});
		chk("split drop", 35'(rt.drop), 35'(1));
		snd({1'b1, 3'h0, 5'd4, 32'h917});
		chk("split high", rt, rx(16'h0200, 16'h0200));
		wr(RCFU_A_MODE, 32'h88);
	endtask : t_split
	task automatic t_table;
		wr(RCFU_A_TBL_ADDR, 32'h5);
		wr(RCFU_A_TBL_DATA, 32'h000c);
		snd({1'b0, 3'h0, 5'd6, 32'h5});
		chk("table", rt, rx(16'h000c, 16'h000c));
		wr(RCFU_A_MODE, 32'h0020_0088);
		snd({1'b0, 3'h0, 5'd6, 32'h50});
		chk("table shift", rt, rx(16'h000c, 16'h000c));
		wr(RCFU_A_MODE, 32'h4080);
		snd({1'b0, 3'h0, 5'd6, 32'h5});
		chk("ignore mc", rt, rx(16'h0020, 16'h0020));
	endtask : t_table
	task automatic t_stage;
		wr(RCFU_A_MODE, 32'h88);
		wr(RCFU_A_STAGE, 32'h3);
		wr(RCFU_A_FMASK, 32'hff00_0000);
		snd({1'b0, 3'h3, 5'd1, 32'h400});
		chk("extract", 35'(rt.extract), 35'(1));
		snd({1'b1, 3'h3, 5'd1, 32'h0100_0400});
		chk("filter first", 35'({rt.drop, rt.extract}), 35'(2));
		snd({1'b0, 3'h2, 5'd1, 32'h400});
		chk("other stage", rt, rx(16'h0010, 16'h0010));
		wr(RCFU_A_MODE, 32'h8088);
		snd({1'b1, 3'h0, 5'd1, 32'h400});
		chk("blocked", 35'(rt.drop), 35'(1));
		snd({1'b1, 3'h3, 5'd1, 32'h500});
		chk("comm cell", 35'(rt.extract), 35'(1));
		rd(RCFU_A_STATUS, 32'h2);
		rd(RCFU_A_RXDATA, 32'h400);
		rd(RCFU_A_RXDATA, 32'h500);
		rd(RCFU_A_RXDATA, 32'h0);
		// five extractions into a four deep queue
		for (int k = 0; k < 5; k++) snd({1'b1, 3'h3, 5'd1, 32'(k)});
		rd(RCFU_A_STATUS, 32'hc);
		wr(RCFU_A_STATUS, 32'h8);
		rd(RCFU_A_STATUS, 32'h4);
		for (int k = 0; k < 4; k++) rd(RCFU_A_RXDATA, 32'(k));
		wr(RCFU_A_FMASK, 32'h0);
	endtask : t_stage
	task automatic t_tx;
		wr(RCFU_A_MODE, 32'h0002_0088);
		// a scrambled map must not steer test cells
		wr(RCFU_A_QMAP_LO, 32'h0);
		wr(RCFU_A_TX0, 32'h6);
		wv;
		chk("tx0", 35'({rt.test, rt.ports}), 35'({1'b1, 16'h0040}));
		wr(RCFU_A_TX1, 32'h9);
		wv;
		chk("tx1", 35'({rt.test, rt.ports}), 35'({1'b1, 16'h0200}));
		wr(RCFU_A_QMAP_LO, RCFU_QMAP_RST[31:0]);
	endtask : t_tx
	initial begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		t_self;
		t_filter;
		t_bundle;
		t_split;
		t_table;
		t_stage;
		t_tx;
		close_out;
	end
	// tests need a few hundred cycles; this leaves ample margin
	initial begin
		#100000;
		bad_count++;
		close_out;
	end
endmodule : rcfu_top_test
